// ---- shared/hufc_map.vh ----
// Register map, field positions and timing constants of the HCI serial port
`ifndef HUFC_MAP_VH
`define HUFC_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define HUFC_ADR_CTRL 8'h00
`define HUFC_ADR_DIV 8'h04
`define HUFC_ADR_STAT 8'h08
`define HUFC_ADR_TXDATA 8'h0c
`define HUFC_ADR_RXDATA 8'h10
`define HUFC_ADR_ABAUD 8'h14

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define HUFC_CTRL_SWFC 0
`define HUFC_CTRL_SLIP 1
`define HUFC_CTRL_ABAUD 2
`define HUFC_CTRL_SLEEP 3
`define HUFC_CTRL_W 4
`define HUFC_CTRL_RST 4'h0

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define HUFC_ST_TXFULL 0
`define HUFC_ST_RXEMPTY 1
`define HUFC_ST_ABDONE 2
`define HUFC_ST_PAUSED 3
`define HUFC_ST_OVERRUN 4
`define HUFC_ST_RTS 5
`define HUFC_ST_CTS 6
`define HUFC_ST_TXBUSY 7

// ----------------------------------------------------------------------
// Line rate and character codes
// ----------------------------------------------------------------------
`define HUFC_CLK_HZ 250000000
`define HUFC_RESET_BAUD 115200
`define HUFC_MIN_BAUD 9600
`define HUFC_MAX_BAUD 4000000
`define HUFC_DIV_W 16
`define HUFC_FIFO_DEPTH 1040
`define HUFC_RTS_HI_GAP 16
`define HUFC_XON 8'h11
`define HUFC_XOFF 8'h13
`define HUFC_SLIP_END 8'hc0
`define HUFC_SLIP_ESC 8'hdb
`define HUFC_SLIP_ESC_END 8'hdc
`define HUFC_SLIP_ESC_ESC 8'hdd

`endif

// ---- rtl/hufc_fifo.v ----
// Byte FIFO with valid/ready on both sides and an occupancy count
`timescale 1ns/100ps
module hufc_fifo #(
  parameter W = 9,
  parameter DEPTH = 1040,
  parameter AW = 11
) (
  input wire core_clk_in,
  input wire reset_in,
  input wire wr_valid_in,
  input wire [W-1:0] wr_data_in,
  output wire wr_ready_out,
  output wire rd_valid_out,
  output wire [W-1:0] rd_data_out,
  input wire rd_ready_in,
  output wire [AW:0] count_out
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_r;
  reg [AW-1:0] rptr_r;
  reg [AW:0] count_r;
  wire do_wr;
  wire do_rd;

  function [AW-1:0] nxt_ptr;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1) begin
        nxt_ptr = {AW{1'b0}};
      end else begin
        nxt_ptr = p + 1'b1;
      end
    end
  endfunction

  assign wr_ready_out = (count_r != DEPTH);
  assign rd_valid_out = (count_r != {(AW+1){1'b0}});
  assign rd_data_out = mem[rptr_r];
  assign count_out = count_r;
  assign do_wr = wr_valid_in && wr_ready_out;
  assign do_rd = rd_ready_in && rd_valid_out;

  always @(posedge core_clk_in) begin
    if (do_wr) begin
      mem[wptr_r] <= wr_data_in;
    end
  end

  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      wptr_r <= {AW{1'b0}};
      rptr_r <= {AW{1'b0}};
      count_r <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wptr_r <= nxt_ptr(wptr_r);
      end
      if (do_rd) begin
        rptr_r <= nxt_ptr(rptr_r);
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // hufc_fifo

// ---- rtl/hufc_top.v ----
// HCI serial port: rate generator, framing, flow control, SLIP assist, wake
//
// Contract
// - Four wires; programmable line rates from 9600 bps to 4.0 Mbps.
// - Detect incoming line rate automatically and report the chosen divider.
// - After reset the line rate is 115.2 kilobaud.
// - Divider loadable from a configuration write or from auto-detection.
// - Host may rewrite the divider at run time; new rate takes effect.
// - Combined device and host rate error must stay within two percent.
// - Separate 1040-byte receive and transmit FIFOs.
// - Both FIFOs reachable from the internal bus, by DMA or processor.
// - Carries H4 raw traffic and H5 three-wire framed traffic.
// - XOFF received pauses transmit; XON resumes it.
// - SLIP assist: frame delimiters and escaping of special bytes.
// - While asleep, any edge on serial in or clear-to-send wakes.
// - Drive serial out, accept serial in for the HCI link.
// - Request-to-send is active low, meaning device can accept data.
// - Transmit data valid within 1.5 bit periods of clear-to-send low.
// - Request-to-send rises no later than half a bit after stop middle.
`timescale 1ns/100ps
`include "hufc_map.vh"
module hufc_top #(
  parameter DEPTH = `HUFC_FIFO_DEPTH,
  parameter AW = 11
) (
  input wire core_clk_in,
  input wire reset_in,
  input wire [7:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  output wire [31:0] wb_dat_out,
  input wire [3:0] wb_sel_in,
  input wire wb_we_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  output wire wb_ack_out,
  input wire hci_serial_in,
  input wire hci_clear_to_send_n_in,
  output wire hci_serial_out,
  output wire hci_request_to_send_n_out,
  output wire tx_dma_req_out,
  output wire rx_dma_req_out,
  output wire wake_event_out
);
  // ----------------------------------------------------------------------
  // Constants and state codes
  // ----------------------------------------------------------------------
  // Rounded to nearest so the reset rate error stays well inside the budget
  localparam integer DIV_RST_I = (`HUFC_CLK_HZ + `HUFC_RESET_BAUD / 2) / `HUFC_RESET_BAUD;
  localparam [`HUFC_DIV_W-1:0] DIV_RST = DIV_RST_I[`HUFC_DIV_W-1:0];
  localparam integer RTS_HI_I = DEPTH - `HUFC_RTS_HI_GAP;
  localparam integer RTS_LO_I = DEPTH / 2;
  localparam [AW:0] RTS_HI = RTS_HI_I[AW:0];
  localparam [AW:0] RTS_LO = RTS_LO_I[AW:0];
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_START = 4'h2;
  localparam [3:0] S_DATA = 4'h4;
  localparam [3:0] S_STOP = 4'h8;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg [1:0] rx_sync_r;
  reg [1:0] cts_sync_r;
  reg rx_prev_r;
  reg cts_prev_r;
  wire rx_s = rx_sync_r[1];
  wire cts_s = cts_sync_r[1];

  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_sync_r <= 2'h3;
      cts_sync_r <= 2'h3;
      rx_prev_r <= 1'b1;
      cts_prev_r <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[0], hci_serial_in};
      cts_sync_r <= {cts_sync_r[0], hci_clear_to_send_n_in};
      rx_prev_r <= rx_s;
      cts_prev_r <= cts_s;
    end
  end

  // ----------------------------------------------------------------------
  // Registers and Wishbone slave
  // ----------------------------------------------------------------------
  reg [`HUFC_CTRL_W-1:0] ctrl_r;
  reg [`HUFC_DIV_W-1:0] div_r;
  reg [`HUFC_DIV_W-1:0] abaud_r;
  reg abdone_r;
  reg overrun_r;
  reg paused_r;
  reg wake_r;
  reg ack_r;
  reg [31:0] rdat_r;
  reg rts_n_r;
  wire req = wb_cyc_in && wb_stb_in && !ack_r;
  wire wr = req && wb_we_in && wb_sel_in[0];
  wire rd = req && !wb_we_in;
  wire wake_edge = ctrl_r[`HUFC_CTRL_SLEEP] && ((rx_s != rx_prev_r) || (cts_s != cts_prev_r));
  wire ab_active = ctrl_r[`HUFC_CTRL_ABAUD];
  reg ab_hit;
  reg [`HUFC_DIV_W-1:0] ab_cnt_r;

  wire txf_ready;
  wire rxf_valid;
  wire [8:0] rxf_data;
  wire [AW:0] rxf_count;
  wire [AW:0] txf_count;
  reg [3:0] tx_st_r;

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdat_r;
  assign wake_event_out = wake_r;
  assign tx_dma_req_out = txf_ready;
  assign rx_dma_req_out = rxf_valid;

  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl_r <= `HUFC_CTRL_RST;
      div_r <= DIV_RST;
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
      wake_r <= 1'b0;
    end else begin
      ack_r <= req;
      wake_r <= wake_edge;
      if (wr && wb_adr_in == `HUFC_ADR_CTRL) begin
        ctrl_r <= wb_dat_in[`HUFC_CTRL_W-1:0];
      end
      if (wake_edge) begin
        ctrl_r[`HUFC_CTRL_SLEEP] <= 1'b0;
      end
      if (ab_hit) begin
        ctrl_r[`HUFC_CTRL_ABAUD] <= 1'b0;
        div_r <= ab_cnt_r;
      end else if (wr && wb_adr_in == `HUFC_ADR_DIV) begin
        div_r <= wb_dat_in[`HUFC_DIV_W-1:0];
      end
      rdat_r <= 32'h0;
      if (rd) begin
        case (wb_adr_in)
          `HUFC_ADR_CTRL: rdat_r <= {{(32-`HUFC_CTRL_W){1'b0}}, ctrl_r};
          `HUFC_ADR_DIV: rdat_r <= {{(32-`HUFC_DIV_W){1'b0}}, div_r};
          `HUFC_ADR_STAT: begin
            rdat_r[`HUFC_ST_TXFULL] <= !txf_ready;
            rdat_r[`HUFC_ST_RXEMPTY] <= !rxf_valid;
            rdat_r[`HUFC_ST_ABDONE] <= abdone_r;
            rdat_r[`HUFC_ST_PAUSED] <= paused_r;
            rdat_r[`HUFC_ST_OVERRUN] <= overrun_r;
            rdat_r[`HUFC_ST_RTS] <= rts_n_r;
            rdat_r[`HUFC_ST_CTS] <= cts_s;
            rdat_r[`HUFC_ST_TXBUSY] <= (tx_st_r != S_IDLE);
          end
          `HUFC_ADR_RXDATA: rdat_r <= {rxf_valid, 22'h0, rxf_data};
          `HUFC_ADR_ABAUD: rdat_r <= {{(32-`HUFC_DIV_W){1'b0}}, abaud_r};
          default: rdat_r <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Rate detection: width of a lone low start bit gives clocks per bit
  // ----------------------------------------------------------------------
  // Needs a first character whose bit 0 is one, such as an HCI packet type
  always @* begin
    ab_hit = ab_active && abdone_r == 1'b0 && rx_s && !rx_prev_r && ab_cnt_r != 16'h0;
  end

  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ab_cnt_r <= 16'h0;
      abaud_r <= 16'h0;
      abdone_r <= 1'b0;
    end else begin
      if (!ab_active) begin
        ab_cnt_r <= 16'h0;
      end else if (!rx_s && ab_cnt_r != 16'hffff) begin
        ab_cnt_r <= ab_cnt_r + 1'b1;
      end
      if (ab_hit) begin
        abaud_r <= ab_cnt_r;
        abdone_r <= 1'b1;
      end else if (wr && wb_adr_in == `HUFC_ADR_CTRL && wb_dat_in[`HUFC_CTRL_ABAUD]) begin
        abdone_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------------
  wire txf_valid;
  wire [8:0] txf_data;
  reg txf_pop;
  reg rxf_push;
  reg [8:0] rxf_wdata;
  wire rxf_ready;
  wire txf_push = wr && wb_adr_in == `HUFC_ADR_TXDATA;
  wire rxf_pop = rd && wb_adr_in == `HUFC_ADR_RXDATA;

  hufc_fifo #(.W(9), .DEPTH(DEPTH), .AW(AW)) u_txf (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .wr_valid_in(txf_push),
    .wr_data_in(wb_dat_in[8:0]),
    .wr_ready_out(txf_ready),
    .rd_valid_out(txf_valid),
    .rd_data_out(txf_data),
    .rd_ready_in(txf_pop),
    .count_out(txf_count)
  );

  hufc_fifo #(.W(9), .DEPTH(DEPTH), .AW(AW)) u_rxf (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .wr_valid_in(rxf_push),
    .wr_data_in(rxf_wdata),
    .wr_ready_out(rxf_ready),
    .rd_valid_out(rxf_valid),
    .rd_data_out(rxf_data),
    .rd_ready_in(rxf_pop),
    .count_out(rxf_count)
  );

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  reg [`HUFC_DIV_W-1:0] tx_cnt_r;
  reg [2:0] tx_bit_r;
  reg [7:0] tx_sh_r;
  reg tx_out_r;
  reg esc_pend_r;
  reg [7:0] esc_byte_r;
  wire tx_tick = (tx_cnt_r >= div_r - 1'b1);
  wire slip_on = ctrl_r[`HUFC_CTRL_SLIP];
  wire tx_go = tx_st_r == S_IDLE && !cts_s && !paused_r && (esc_pend_r || txf_valid);
  wire tx_special = slip_on && !txf_data[8] &&
    (txf_data[7:0] == `HUFC_SLIP_END || txf_data[7:0] == `HUFC_SLIP_ESC);

  assign hci_serial_out = tx_out_r;

  always @* begin
    txf_pop = tx_go && !esc_pend_r;
  end

  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_st_r <= S_IDLE;
      tx_cnt_r <= 16'h0;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h0;
      tx_out_r <= 1'b1;
      esc_pend_r <= 1'b0;
      esc_byte_r <= 8'h0;
    end else begin
      tx_cnt_r <= (tx_st_r == S_IDLE || tx_tick) ? 16'h0 : tx_cnt_r + 1'b1;
      case (tx_st_r)
        S_IDLE: begin
          tx_out_r <= 1'b1;
          if (tx_go) begin
            tx_st_r <= S_START;
            tx_out_r <= 1'b0;
            if (esc_pend_r) begin
              tx_sh_r <= esc_byte_r;
              esc_pend_r <= 1'b0;
            end else if (txf_data[8] && slip_on) begin
              tx_sh_r <= `HUFC_SLIP_END;
            end else if (tx_special) begin
              tx_sh_r <= `HUFC_SLIP_ESC;
              esc_pend_r <= 1'b1;
              esc_byte_r <= (txf_data[7:0] == `HUFC_SLIP_END) ? `HUFC_SLIP_ESC_END : `HUFC_SLIP_ESC_ESC;
            end else begin
              tx_sh_r <= txf_data[7:0];
            end
          end
        end
        S_START: begin
          if (tx_tick) begin
            tx_st_r <= S_DATA;
            tx_out_r <= tx_sh_r[0];
            tx_bit_r <= 3'h0;
          end
        end
        S_DATA: begin
          if (tx_tick) begin
            if (tx_bit_r == 3'h7) begin
              tx_st_r <= S_STOP;
              tx_out_r <= 1'b1;
            end else begin
              tx_out_r <= tx_sh_r[1];
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              tx_bit_r <= tx_bit_r + 1'b1;
            end
          end
        end
        S_STOP: begin
          if (tx_tick) begin
            tx_st_r <= S_IDLE;
          end
        end
        default: tx_st_r <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  reg [3:0] rx_st_r;
  reg [`HUFC_DIV_W-1:0] rx_cnt_r;
  reg [2:0] rx_bit_r;
  reg [7:0] rx_sh_r;
  reg rx_esc_r;
  wire rx_tick = (rx_cnt_r >= div_r - 1'b1);
  wire rx_half = (rx_cnt_r >= {1'b0, div_r[`HUFC_DIV_W-1:1]});
  wire swfc_on = ctrl_r[`HUFC_CTRL_SWFC];
  wire stop_ok = rx_st_r == S_STOP && rx_tick && rx_s;
  wire is_fc = swfc_on && (rx_sh_r == `HUFC_XON || rx_sh_r == `HUFC_XOFF);

  always @* begin
    rxf_push = 1'b0;
    rxf_wdata = {1'b0, rx_sh_r};
    if (stop_ok && !is_fc) begin
      if (slip_on && rx_sh_r == `HUFC_SLIP_END) begin
        rxf_push = 1'b1;
        rxf_wdata = {1'b1, `HUFC_SLIP_END};
      end else if (slip_on && rx_sh_r == `HUFC_SLIP_ESC) begin
        rxf_push = 1'b0;
      end else if (slip_on && rx_esc_r) begin
        rxf_push = 1'b1;
        rxf_wdata = {1'b0, (rx_sh_r == `HUFC_SLIP_ESC_END) ? `HUFC_SLIP_END : `HUFC_SLIP_ESC};
      end else begin
        rxf_push = 1'b1;
      end
    end
  end

  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_st_r <= S_IDLE;
      rx_cnt_r <= 16'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h0;
      rx_esc_r <= 1'b0;
      paused_r <= 1'b0;
      overrun_r <= 1'b0;
      rts_n_r <= 1'b1;
    end else begin
      rx_cnt_r <= rx_cnt_r + 1'b1;
      case (rx_st_r)
        S_IDLE: begin
          rx_cnt_r <= 16'h0;
          if (!rx_s && !ab_active) begin
            rx_st_r <= S_START;
          end
        end
        S_START: begin
          if (rx_half) begin
            rx_cnt_r <= 16'h0;
            rx_bit_r <= 3'h0;
            rx_st_r <= rx_s ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_tick) begin
            rx_cnt_r <= 16'h0;
            rx_sh_r <= {rx_s, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 1'b1;
            if (rx_bit_r == 3'h7) begin
              rx_st_r <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (rx_tick) begin
            rx_st_r <= S_IDLE;
          end
        end
        default: rx_st_r <= S_IDLE;
      endcase
      if (stop_ok && is_fc) begin
        paused_r <= (rx_sh_r == `HUFC_XOFF);
      end else if (!swfc_on) begin
        paused_r <= 1'b0;
      end
      if (stop_ok && slip_on) begin
        rx_esc_r <= (rx_sh_r == `HUFC_SLIP_ESC);
      end
      // Overrun is sticky; a clearing write loses to a new overrun
      if (rxf_push && !rxf_ready) begin
        overrun_r <= 1'b1;
      end else if (wr && wb_adr_in == `HUFC_ADR_STAT && wb_dat_in[`HUFC_ST_OVERRUN]) begin
        overrun_r <= 1'b0;
      end
      // Margin of 16 bytes covers a host that finishes its current burst
      if (rxf_count >= RTS_HI) begin
        rts_n_r <= 1'b1;
      end else if (rxf_count < RTS_LO) begin
        rts_n_r <= 1'b0;
      end
    end
  end

  // Push lands at stop-bit middle, so the high level follows one clock later
  assign hci_request_to_send_n_out = rts_n_r;
endmodule // hufc_top

// ---- bench/hufc_host_model.sv ----
// Host-side serial port model: sends and collects 8N1 characters
`timescale 1ns/100ps
module hufc_host_model (
  input wire logic core_clk_in,
  input wire logic dev_tx_in,
  input wire logic dev_rts_n_in,
  output logic host_tx_out,
  output logic host_cts_n_out
);
  // Same clocks per bit as the device, so no rate error at all
  int bit_div = 16;
  logic [7:0] rx_q[$];

  initial begin
    host_tx_out = 1'b1;
    host_cts_n_out = 1'b0;
  end

  task set_cts(input logic v);
    @(posedge core_clk_in);
    host_cts_n_out <= v;
  endtask

  task send(input logic [7:0] b);
    int k;
    logic [9:0] f;
    k = 0;
    f = {1'b1, b, 1'b0};
    // Host holds off while the device refuses data
    while (dev_rts_n_in !== 1'b0 && k < 5000) begin
      @(posedge core_clk_in);
      k++;
    end
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk_in);
      host_tx_out <= f[i];
      repeat (bit_div - 1) @(posedge core_clk_in);
    end
  endtask

  always begin : rx_blk
    logic [7:0] b;
    @(posedge core_clk_in iff dev_tx_in === 1'b0);
    repeat (bit_div / 2) @(posedge core_clk_in);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_div) @(posedge core_clk_in);
      b[i] = dev_tx_in;
    end
    repeat (bit_div) @(posedge core_clk_in);
    // Bad stop bit: character dropped, the bench then times out
    if (dev_tx_in === 1'b1) rx_q.push_back(b);
  end
endmodule // hufc_host_model

// ---- bench/hufc_props.sv ----
// Port-level checker of the HCI serial port
`timescale 1ns/100ps
module hufc_props (
  input wire core_clk_in,
  input wire reset_in,
  input wire [7:0] wb_adr_in,
  input wire [31:0] wb_dat_in,
  input wire [31:0] wb_dat_out,
  input wire [3:0] wb_sel_in,
  input wire wb_we_in,
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_ack_out,
  input wire hci_serial_in,
  input wire hci_clear_to_send_n_in,
  input wire hci_serial_out,
  input wire hci_request_to_send_n_out,
  input wire tx_dma_req_out,
  input wire rx_dma_req_out,
  input wire wake_event_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  logic rx_last_r, cts_last_r;
  logic [3:0] quiet_r;

  // Cycles since the last edge on either wake source
  always @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_last_r <= 1'b1;
      cts_last_r <= 1'b1;
      quiet_r <= 4'h0;
    end else begin
      rx_last_r <= hci_serial_in;
      cts_last_r <= hci_clear_to_send_n_in;
      if (hci_serial_in != rx_last_r || hci_clear_to_send_n_in != cts_last_r) quiet_r <= 4'h0;
      else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
    end
  end

  sequence s_req;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_pulse;
    wb_ack_out ##1 !wb_ack_out;
  endsequence

  a_ack_latency: assert property (s_req |=> s_pulse)
    else $error("ack not a single pulse one cycle after request");
  a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in))
    else $error("ack without a request");
  a_dat_quiet: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack cycle");
  a_reset_lines: assert property ($fell(reset_in) |-> hci_request_to_send_n_out && hci_serial_out
    ##1 !hci_request_to_send_n_out)
    else $error("flow line wrong around reset release");
  a_reset_dma: assert property ($fell(reset_in) |-> tx_dma_req_out && !rx_dma_req_out && !wake_event_out)
    else $error("request lines wrong at reset release");
  a_line_idle: assert property ($fell(reset_in) |-> hci_serial_out [*4])
    else $error("serial out not idle high after reset");
  a_wake_pulse: assert property (wake_event_out |=> !wake_event_out)
    else $error("wake longer than one cycle");
  a_wake_cause: assert property (wake_event_out |-> quiet_r <= 4'h6)
    else $error("wake without a recent line edge");
endmodule // hufc_props

bind hufc_top hufc_props props_u (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_sel_in(wb_sel_in), .wb_we_in(wb_we_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .hci_serial_in(hci_serial_in),
  .hci_clear_to_send_n_in(hci_clear_to_send_n_in), .hci_serial_out(hci_serial_out),
  .hci_request_to_send_n_out(hci_request_to_send_n_out), .tx_dma_req_out(tx_dma_req_out),
  .rx_dma_req_out(rx_dma_req_out), .wake_event_out(wake_event_out));

// ---- bench/test_hci_uart_with_flow_control.sv ----
// Self-checking bench of the HCI serial port against a host model
`timescale 1ns/100ps
`include "hufc_map.vh"
module test_hci_uart_with_flow_control;
  localparam logic [7:0] adr_ct = `HUFC_ADR_CTRL;
  localparam logic [7:0] adr_dv = `HUFC_ADR_DIV;
  localparam logic [7:0] adr_st = `HUFC_ADR_STAT;
  localparam logic [7:0] adr_tx = `HUFC_ADR_TXDATA;
  localparam logic [7:0] adr_rx = `HUFC_ADR_RXDATA;
  localparam logic [7:0] adr_ab = `HUFC_ADR_ABAUD;
  typedef struct packed {logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat; logic [31:0] exp;} hufc_row_t;
  logic core_clk_in, reset_in, wb_we, wb_cyc, wb_stb;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, q;
  wire [31:0] wb_rdat;
  wire wb_ack, ser_out, rts_n, tx_dma, rx_dma, wake, host_tx, cts_n;
  int err_total = 0;
  int compares = 0;
  int n;
  // Register rows: reads compare, writes only drive; 8'h18 is unmapped
  hufc_row_t rows [12] = '{
    '{1'b0, adr_dv, 4'hf, 32'h0, 32'h87a}, '{1'b0, adr_ct, 4'hf, 32'h0, 32'h0},
    '{1'b0, adr_st, 4'hf, 32'h0, 32'h2}, '{1'b0, 8'h18, 4'hf, 32'h0, 32'h0},
    '{1'b1, 8'h18, 4'hf, 32'hffffffff, 32'h0}, '{1'b0, 8'h18, 4'hf, 32'h0, 32'h0},
    '{1'b1, adr_dv, 4'hf, 32'h10, 32'h0}, '{1'b1, adr_dv, 4'he, 32'h20, 32'h0},
    '{1'b0, adr_dv, 4'hf, 32'h0, 32'h10}, '{1'b1, adr_ct, 4'hf, 32'h3, 32'h0},
    '{1'b0, adr_ct, 4'hf, 32'h0, 32'h3}, '{1'b1, adr_ct, 4'hf, 32'h0, 32'h0}};

  hufc_top #(.DEPTH(32), .AW(5)) dut_u (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .wb_adr_in(wb_adr), .wb_dat_in(wb_wdat),
    .wb_dat_out(wb_rdat), .wb_sel_in(wb_sel), .wb_we_in(wb_we), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
    .wb_ack_out(wb_ack), .hci_serial_in(host_tx), .hci_clear_to_send_n_in(cts_n), .hci_serial_out(ser_out),
    .hci_request_to_send_n_out(rts_n), .tx_dma_req_out(tx_dma), .rx_dma_req_out(rx_dma), .wake_event_out(wake));
  hufc_host_model host_u (.core_clk_in(core_clk_in), .dev_tx_in(ser_out), .dev_rts_n_in(rts_n),
    .host_tx_out(host_tx), .host_cts_n_out(cts_n));

  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  task close_out;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task bail;
    err_total++;
    close_out();
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One classic cycle; held until ack is sampled high
  task wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_in);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {1'b1, 1'b1, we, a, s, d};
    do begin
      @(posedge core_clk_in);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    q = wb_rdat;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    if (k >= 20) bail();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hf, d);
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 4'hf, 32'h0);
  endtask
  task wait_rx(input int c);
    n = 0;
    while (host_u.rx_q.size() < c && n < 20000) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n >= 20000) bail();
  endtask
  task got(input logic [7:0] e);
    chk("line_byte", host_u.rx_q.pop_front(), e);
  endtask

  initial begin
    repeat (90000) @(posedge core_clk_in);
    bail();
  end

  initial begin
    {reset_in, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = {1'b1, 3'b000, 8'h0, 4'h0, 32'h0};
    repeat (10) @(posedge core_clk_in);
    reset_in <= 1'b0;
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].sel, rows[i].dat);
      if (!rows[i].we) chk("reg_row", q, rows[i].exp);
    end
    // ----------------------------------------------------------------------
    // Awkward cases
    // ----------------------------------------------------------------------
    wr(adr_tx, 32'ha5);
    wr(adr_tx, 32'h5a);
    wr(adr_tx, 32'h01);
    wait_rx(3);
    got(8'ha5);
    got(8'h5a);
    got(8'h01);
    chk("tx_dma", tx_dma, 1);
    host_u.set_cts(1'b1);
    repeat (4) @(posedge core_clk_in);
    wr(adr_tx, 32'h3c);
    repeat (400) @(posedge core_clk_in);
    chk("cts_hold", {ser_out, host_u.rx_q.size() == 0}, 2'b11);
    host_u.set_cts(1'b0);
    n = 0;
    while (ser_out !== 1'b0 && n < 30) begin
      @(posedge core_clk_in);
      n++;
    end
    chk("cts_delay", n <= 24, 1);
    wait_rx(1);
    got(8'h3c);
    host_u.send(8'h96);
    repeat (8) @(posedge core_clk_in);
    chk("rx_dma", rx_dma, 1);
    rd(adr_rx);
    chk("rx_byte", q, 32'h80000096);
    wr(adr_ct, 32'h1);
    host_u.send(`HUFC_XOFF);
    repeat (8) @(posedge core_clk_in);
    wr(adr_tx, 32'h77);
    repeat (400) @(posedge core_clk_in);
    chk("xoff_hold", host_u.rx_q.size(), 0);
    rd(adr_st);
    chk("paused", q[3], 1);
    rd(adr_rx);
    chk("xoff_eaten", q[31], 0);
    host_u.send(`HUFC_XON);
    wait_rx(1);
    got(8'h77);
    wr(adr_ct, 32'h2);
    wr(adr_tx, 32'hc0);
    wr(adr_tx, 32'h100);
    wait_rx(3);
    got(8'hdb);
    got(8'hdc);
    got(8'hc0);
    host_u.send(8'hdb);
    host_u.send(8'hdd);
    repeat (8) @(posedge core_clk_in);
    rd(adr_rx);
    chk("slip_rx", q, 32'h800000db);
    wr(adr_ct, 32'h8);
    host_u.set_cts(1'b1);
    n = 0;
    while (wake !== 1'b1 && n < 20) begin
      @(posedge core_clk_in);
      n++;
    end
    chk("wake", wake, 1);
    host_u.set_cts(1'b0);
    rd(adr_ct);
    chk("sleep_clear", q, 0);
    // Fill the receive side until the flow line refuses
    wr(adr_ct, 32'h0);
    for (int i = 0; i < 16; i++) host_u.send(8'h40 + i[7:0]);
    chk("rts_full", rts_n, 1);
    rd(adr_rx);
    chk("rx_first", q, 32'h80000040);
    @(posedge core_clk_in);
    reset_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    reset_in <= 1'b0;
    rd(adr_dv);
    chk("div_reset", q, 32'h87a);
    wr(adr_ct, 32'h4);
    host_u.bit_div = 24;
    host_u.send(8'h01);
    repeat (40) @(posedge core_clk_in);
    rd(adr_ab);
    chk("abaud", q, 32'd24);
    rd(adr_dv);
    chk("div_auto", q, 32'd24);
    rd(adr_st);
    chk("ab_done", q[2], 1);
    close_out();
  end
endmodule // test_hci_uart_with_flow_control
